// File: hfcrc_map.svh
// Register offsets, field positions, reset values and timing figures
// for the high-frequency clock request controller.
// Assumes a 32-bit APB slave with 12-bit byte addresses.
`ifndef HFCRC_MAP_SVH
`define HFCRC_MAP_SVH

`define HFCRC_ADDR_W            12
`define HFCRC_OFF_START_TASK    12'h0000
`define HFCRC_OFF_STOP_TASK     12'h0004
`define HFCRC_OFF_STARTED_EVT   12'h0100
`define HFCRC_OFF_SOURCE_SEL    12'h0200
`define HFCRC_OFF_STATUS        12'h0204
`define HFCRC_OFF_MODE          12'h0208

`define HFCRC_BIT_TRIGGER       0
`define HFCRC_BIT_SRC           0
`define HFCRC_BIT_CONSTLAT      0
`define HFCRC_RST_SOURCE_SEL    1'h0
`define HFCRC_RST_CONSTLAT      1'h0

// Core clock indices and the root clock that feeds each one.
`define HFCRC_N_CORE_CLK        8
`define HFCRC_N_ROOT            4
`define HFCRC_ROOT_128          0
`define HFCRC_ROOT_64           1
`define HFCRC_ROOT_192          2
`define HFCRC_ROOT_AUDIO        3
`define HFCRC_ROOT_OF_CLK       {3'h3, 3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 3'h0}

// Timing figures as printed, and the clock rate.
`define HFCRC_CLK_MHZ           10
`define HFCRC_T_EVT_NS          62.5
`define HFCRC_T_APP_IDLE_US     23
`define HFCRC_T_APP_CL_US       10
`define HFCRC_T_APP_OFF_US      38
`define HFCRC_T_NET_IDLE_US     15
`define HFCRC_T_NET_CL_US       7
`define HFCRC_T_NET_HOLD_US     20
`define HFCRC_STABLE_CYC        16

`endif

// File: hfcrc_pkg.sv
// Types shared by the high-frequency clock request controller.
// Assumes the map header supplies all numeric constants.
package hfcrc_pkg;

    typedef enum logic {
        HFCRC_SRC_INTERNAL = 1'b0,
        HFCRC_SRC_CRYSTAL  = 1'b1
    } hfcrc_src_t;

    typedef enum logic [1:0] {
        HFCRC_ST_IDLE = 2'b00,
        HFCRC_ST_WAIT = 2'b01,
        HFCRC_ST_STAB = 2'b10,
        HFCRC_ST_RUN  = 2'b11
    } hfcrc_state_t;

    typedef struct packed {
        logic audio;
        logic r192;
        logic r64;
        logic r128;
    } hfcrc_roots_t;

endpackage : hfcrc_pkg

// File: hfcrc_top.sv
// Local high-frequency clock request controller for one core.
// Assumes an APB master on mclk_in, consumer requests, hardware events
// and wake causes from logic on mclk_in, and pin-level status from the
// shared power and clock subsystem, which is synchronised here.
//
// Summary of operation
// - Each core owns this controller; it requests oscillators and roots.
// - Each core clock has its own gate, closed when nobody consumes it.
// - Gates change only from registers and close across a source change.
// - Eight core clocks are gated: CPU, flash, USB, peripheral, audio.
// - Four root clocks are requested: 128, 64, 192 MHz and audio.
// - Roots come from the internal oscillator or the 32 MHz crystal.
// - Requests are forwarded; a gate opens only after its root runs.
// - With no local consumer the root request is withdrawn.
// - A root is demanded only while some core requests it.
// - In system-on, demand enables the internal oscillator by default.
// - Internal oscillator enable drops when all demand is withdrawn.
// - No root request and no gate while system-on is absent.
// - Restarting the active source while it is ready and in the run state skips the start-up wait.
// - The start task starts the source held in the select register.
// - Select writes take effect only at the next start task.
// - Hardware events reach the event interconnect after one clock, 100 ns at 10 MHz, not within 62.5 ns.
// - Application CPU resumes from idle after 23 us, 10 us constlat.
// - Network CPU resumes from idle after 15 us, 7 us constlat.
// - Network core runs 20 us after its hold-off is released.
// - Application CPU runs 38 us after wake from off.
// - Started event only after trigger, running and stabilised source.
// - Retrigger before the event yields one event for the last trigger.
`timescale 1ns/1ps
`include "hfcrc_map.svh"

module hfcrc_top (
    input  wire logic                        mclk_in,
    input  wire logic                        rstn_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [`HFCRC_ADDR_W-1:0]    paddr_in,
    input  wire logic [31:0]                 pwdata_in,
    output logic      [31:0]                 prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    input  wire logic [`HFCRC_N_CORE_CLK-1:0] consumer_req_in,
    input  wire hfcrc_pkg::hfcrc_roots_t     far_root_req_in,
    input  wire hfcrc_pkg::hfcrc_roots_t     root_running_in,
    input  wire logic                        sys_on_in,
    input  wire logic                        int_osc_ready_in,
    input  wire logic                        xo_ready_in,
    input  wire logic [3:0]                  hw_event_in,
    input  wire logic                        app_wake_idle_in,
    input  wire logic                        app_wake_off_in,
    input  wire logic                        net_wake_idle_in,
    input  wire logic                        net_hold_release_in,
    output logic [`HFCRC_N_CORE_CLK-1:0]     clock_gate_en_out,
    output hfcrc_pkg::hfcrc_roots_t          root_req_out,
    output logic                             int_osc_en_out,
    output logic                             xo_en_out,
    output logic                             started_event_out,
    output logic [3:0]                       periph_event_out,
    output logic                             app_cpu_run_out,
    output logic                             net_cpu_run_out
);

    ////////////////////////////////////////////////////////////////////
    // Timing counts derived from the printed times.

    localparam real EVT_NS      = `HFCRC_T_EVT_NS;
    localparam int  EVT_RAW     = int'($floor(EVT_NS * `HFCRC_CLK_MHZ
                                              / 1000.0));
    localparam int  EVT_CYC     = (EVT_RAW < 1) ? 1 : EVT_RAW;
    localparam int  APP_IDLE_C  = `HFCRC_T_APP_IDLE_US * `HFCRC_CLK_MHZ;
    localparam int  APP_CL_C    = `HFCRC_T_APP_CL_US * `HFCRC_CLK_MHZ;
    localparam int  APP_OFF_C   = `HFCRC_T_APP_OFF_US * `HFCRC_CLK_MHZ;
    localparam int  NET_IDLE_C  = `HFCRC_T_NET_IDLE_US * `HFCRC_CLK_MHZ;
    localparam int  NET_CL_C    = `HFCRC_T_NET_CL_US * `HFCRC_CLK_MHZ;
    localparam int  NET_HOLD_C  = `HFCRC_T_NET_HOLD_US * `HFCRC_CLK_MHZ;
    localparam int  STAB_C      = `HFCRC_STABLE_CYC;
    localparam logic [`HFCRC_N_CORE_CLK*3-1:0] ROOT_MAP =
        `HFCRC_ROOT_OF_CLK;

    ////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers.

    logic       rst_meta;
    logic       rst_n;
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic       sys_on;
    logic [3:0] root_run;
    logic       int_ready;
    logic       xo_ready;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 7'h00;
            pin_sync <= 7'h00;
        end else begin
            pin_meta <= {xo_ready_in, int_osc_ready_in, sys_on_in,
                         root_running_in};
            pin_sync <= pin_meta;
        end
    end

    assign root_run  = pin_sync[3:0];
    assign sys_on    = pin_sync[4];
    assign int_ready = pin_sync[5];
    assign xo_ready  = pin_sync[6];

    ////////////////////////////////////////////////////////////////////
    // APB slave. Read data and the answer are prepared in the setup
    // cycle, so every access completes with no wait state.

    logic                   wr_ok;
    logic                   setup;
    logic                   start_task;
    logic                   stop_task;
    logic                   evt_clear;
    logic                   mapped;
    logic [31:0]            rd_mux;
    hfcrc_pkg::hfcrc_src_t  src_sel;
    hfcrc_pkg::hfcrc_src_t  active_src;
    hfcrc_pkg::hfcrc_state_t state;
    logic                   constlat;
    logic                   evt_flag;
    logic [3:0]             root_req_v;

    assign setup = psel_in && !penable_in;
    assign wr_ok = psel_in && penable_in && pready_out && pwrite_in;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr_in == `HFCRC_OFF_START_TASK) begin
            rd_mux = 32'h0000_0000;
        end else if (paddr_in == `HFCRC_OFF_STOP_TASK) begin
            rd_mux = 32'h0000_0000;
        end else if (paddr_in == `HFCRC_OFF_STARTED_EVT) begin
            rd_mux[`HFCRC_BIT_TRIGGER] = evt_flag;
        end else if (paddr_in == `HFCRC_OFF_SOURCE_SEL) begin
            rd_mux[`HFCRC_BIT_SRC] = src_sel;
        end else if (paddr_in == `HFCRC_OFF_STATUS) begin
            rd_mux[0]    = (state == hfcrc_pkg::HFCRC_ST_RUN);
            rd_mux[1]    = active_src;
            rd_mux[7:4]  = root_req_v;
            rd_mux[11:8] = root_run;
        end else if (paddr_in == `HFCRC_OFF_MODE) begin
            rd_mux[`HFCRC_BIT_CONSTLAT] = constlat;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= setup;
            pslverr_out <= setup && !mapped;
            if (setup && !pwrite_in) begin
                prdata_out <= rd_mux;
            end
        end
    end

    assign start_task = wr_ok && (paddr_in == `HFCRC_OFF_START_TASK)
                        && pwdata_in[`HFCRC_BIT_TRIGGER];
    assign stop_task  = wr_ok && (paddr_in == `HFCRC_OFF_STOP_TASK)
                        && pwdata_in[`HFCRC_BIT_TRIGGER];
    assign evt_clear  = wr_ok && (paddr_in == `HFCRC_OFF_STARTED_EVT)
                        && !pwdata_in[`HFCRC_BIT_TRIGGER];

    // Software may rewrite the select at any time; it is only copied
    // into the active source by the start task.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            src_sel  <= hfcrc_pkg::hfcrc_src_t'(`HFCRC_RST_SOURCE_SEL);
            constlat <= `HFCRC_RST_CONSTLAT;
        end else if (wr_ok && paddr_in == `HFCRC_OFF_SOURCE_SEL) begin
            src_sel  <= hfcrc_pkg::hfcrc_src_t'(pwdata_in[`HFCRC_BIT_SRC]);
        end else if (wr_ok && paddr_in == `HFCRC_OFF_MODE) begin
            constlat <= pwdata_in[`HFCRC_BIT_CONSTLAT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Start task sequencer.

    logic       sel_ready;
    logic       new_ready;
    logic [4:0] stab_cnt;

    assign sel_ready = (active_src == hfcrc_pkg::HFCRC_SRC_CRYSTAL)
                       ? xo_ready : int_ready;
    assign new_ready = (src_sel == hfcrc_pkg::HFCRC_SRC_CRYSTAL)
                       ? xo_ready : int_ready;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state             <= hfcrc_pkg::HFCRC_ST_IDLE;
            active_src        <= hfcrc_pkg::HFCRC_SRC_INTERNAL;
            stab_cnt          <= 5'h00;
            started_event_out <= 1'b0;
        end else begin
            started_event_out <= 1'b0;
            if (start_task) begin
                active_src <= src_sel;
                // A retrigger restarts the wait, so only the last one
                // ever produces the event.
                if (new_ready && (src_sel == active_src)
                    && (state == hfcrc_pkg::HFCRC_ST_RUN)) begin
                    state             <= hfcrc_pkg::HFCRC_ST_RUN;
                    started_event_out <= 1'b1;
                end else begin
                    state    <= hfcrc_pkg::HFCRC_ST_WAIT;
                    stab_cnt <= 5'(STAB_C);
                end
            end else if (stop_task) begin
                state <= hfcrc_pkg::HFCRC_ST_IDLE;
            end else begin
                case (state)
                    hfcrc_pkg::HFCRC_ST_WAIT: begin
                        if (sel_ready) begin
                            state <= hfcrc_pkg::HFCRC_ST_STAB;
                        end
                    end
                    hfcrc_pkg::HFCRC_ST_STAB: begin
                        if (!sel_ready) begin
                            state <= hfcrc_pkg::HFCRC_ST_WAIT;
                        end else if (stab_cnt == 5'h01) begin
                            state             <= hfcrc_pkg::HFCRC_ST_RUN;
                            started_event_out <= 1'b1;
                        end else begin
                            stab_cnt <= stab_cnt - 5'h01;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // A new event wins over a software clear in the same cycle.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            evt_flag <= 1'b0;
        end else if (started_event_out) begin
            evt_flag <= 1'b1;
        end else if (evt_clear) begin
            evt_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Root requests, oscillator enables and clock gates.

    logic [3:0]                  local_dem;
    logic [3:0]                  all_dem;
    logic [`HFCRC_N_CORE_CLK-1:0] next_gate;
    logic                        src_chg;
    logic                        xo_keep;

    always_comb begin
        local_dem = 4'h0;
        next_gate = '0;
        for (int i = 0; i < `HFCRC_N_CORE_CLK; i++) begin
            if (consumer_req_in[i]) begin
                local_dem[ROOT_MAP[i*3 +: 2]] = 1'b1;
            end
            next_gate[i] = consumer_req_in[i] && sys_on && !src_chg
                           && root_run[ROOT_MAP[i*3 +: 2]];
        end
    end

    assign all_dem = (local_dem | 4'(far_root_req_in)) & {4{sys_on}};
    assign xo_keep = (active_src == hfcrc_pkg::HFCRC_SRC_CRYSTAL)
                     && (state != hfcrc_pkg::HFCRC_ST_IDLE);
    assign root_req_v = 4'(root_req_out);

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            src_chg <= 1'b0;
        end else begin
            src_chg <= start_task && (src_sel != active_src);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            root_req_out      <= '0;
            clock_gate_en_out <= '0;
            int_osc_en_out    <= 1'b0;
            xo_en_out         <= 1'b0;
        end else begin
            root_req_out      <= hfcrc_pkg::hfcrc_roots_t'(
                                 local_dem & {4{sys_on}});
            clock_gate_en_out <= next_gate;
            // The internal oscillator is the default source and idles
            // once the crystal has taken over or demand is gone.
            int_osc_en_out    <= (|all_dem) && !(xo_keep && xo_ready);
            xo_en_out         <= sys_on && (xo_keep
                                 || all_dem[`HFCRC_ROOT_AUDIO]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event interconnect forwarding.

    logic [3:0] evt_pipe [EVT_CYC];

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < EVT_CYC; i++) begin
                evt_pipe[i] <= 4'h0;
            end
        end else begin
            evt_pipe[0] <= hw_event_in;
            for (int i = 1; i < EVT_CYC; i++) begin
                evt_pipe[i] <= evt_pipe[i-1];
            end
        end
    end

    assign periph_event_out = evt_pipe[EVT_CYC-1];

    ////////////////////////////////////////////////////////////////////
    // Wake latency counters for both CPUs.

    logic [8:0] app_cnt;
    logic [8:0] net_cnt;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            app_cnt         <= 9'h000;
            app_cpu_run_out <= 1'b0;
        end else if (app_wake_off_in) begin
            app_cnt         <= 9'(APP_OFF_C);
            app_cpu_run_out <= 1'b0;
        end else if (app_wake_idle_in) begin
            app_cnt         <= constlat ? 9'(APP_CL_C)
                                        : 9'(APP_IDLE_C);
            app_cpu_run_out <= 1'b0;
        end else if (app_cnt != 9'h000) begin
            app_cnt <= app_cnt - 9'h001;
            if (app_cnt == 9'h001) begin
                app_cpu_run_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            net_cnt         <= 9'h000;
            net_cpu_run_out <= 1'b0;
        end else if (net_hold_release_in) begin
            net_cnt         <= 9'(NET_HOLD_C);
            net_cpu_run_out <= 1'b0;
        end else if (net_wake_idle_in) begin
            net_cnt         <= constlat ? 9'(NET_CL_C)
                                        : 9'(NET_IDLE_C);
            net_cpu_run_out <= 1'b0;
        end else if (net_cnt != 9'h000) begin
            net_cnt <= net_cnt - 9'h001;
            if (net_cnt == 9'h001) begin
                net_cpu_run_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    // The run outputs rise on the edge where their counter reaches zero and
    // are sampled one edge later, so each latency check allows one cycle
    // beyond the nominal count.
    localparam logic [8:0] APP_CL_END = 9'(APP_CL_C + 1);
    localparam int         NET_CL_W   = NET_CL_C + 1;

    // Counts cycles since a constant-latency idle wake of the application
    // CPU, since a repetition of that length would be far too slow.
    logic [8:0] app_chk;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            app_chk <= 9'h000;
        end else if (app_wake_idle_in && constlat && !app_wake_off_in) begin
            app_chk <= 9'h001;
        end else if (app_wake_idle_in || app_wake_off_in) begin
            app_chk <= 9'h000;
        end else if (app_chk != 9'h000) begin
            app_chk <= (app_chk == APP_CL_END) ? 9'h000
                                               : app_chk + 9'h001;
        end
    end

    sequence s_retrigger;
        start_task ##1 (!started_event_out && !stop_task && !start_task)
            [*2] ##1 (start_task && state != hfcrc_pkg::HFCRC_ST_RUN);
    endsequence

    sequence s_app_cl_wake;
        app_wake_idle_in && constlat && !app_wake_off_in;
    endsequence

    AST_FWD_REQ: assert property (@(posedge mclk_in) disable iff (!rst_n)
        (consumer_req_in[0] && sys_on) |=> root_req_out.r128)
        else $error("Consumer request was not forwarded.");

    AST_GATE_AFTER_ROOT: assert property (@(posedge mclk_in)
        disable iff (!rst_n)
        clock_gate_en_out[2] |-> $past(root_run[`HFCRC_ROOT_192]))
        else $error("Gate opened before its root clock ran.");

    AST_WITHDRAW: assert property (@(posedge mclk_in) disable iff (!rst_n)
        (consumer_req_in == '0) |=> (root_req_out == '0))
        else $error("Root request held with no consumer.");

    AST_OFF_STATE: assert property (@(posedge mclk_in) disable iff (!rst_n)
        !sys_on |=> (clock_gate_en_out == '0) && !int_osc_en_out)
        else $error("Clock offered outside system-on.");

    AST_SRC_LATCH: assert property (@(posedge mclk_in) disable iff (!rst_n)
        start_task |=> (active_src == $past(src_sel)))
        else $error("Start task did not take the selected source.");

    AST_SRC_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_n)
        !start_task |=> $stable(active_src))
        else $error("Active source changed without a start task.");

    AST_EVT_READY: assert property (@(posedge mclk_in) disable iff (!rst_n)
        started_event_out |-> sel_ready && state == hfcrc_pkg::HFCRC_ST_RUN)
        else $error("Started event without a running source.");

    AST_ONE_EVENT: assert property (@(posedge mclk_in) disable iff (!rst_n)
        s_retrigger |=> !started_event_out [*8])
        else $error("Superseded start produced an event.");

    AST_EVT_LAT: assert property (@(posedge mclk_in) disable iff (!rst_n)
        hw_event_in[0] |-> ##1 periph_event_out[0])
        else $error("Hardware event not forwarded in time.");

    AST_APP_WAKE: assert property (@(posedge mclk_in) disable iff (!rst_n)
        (app_chk == APP_CL_END) |-> app_cpu_run_out
                                    && !$past(app_cpu_run_out))
        else $error("Application CPU wake latency wrong.");

    AST_APP_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_n)
        s_app_cl_wake |=> !app_cpu_run_out)
        else $error("Application CPU ran before its wake delay.");

    AST_NET_WAKE: assert property (@(posedge mclk_in) disable iff (!rst_n)
        (net_wake_idle_in && constlat && !net_hold_release_in)
        |-> ##[1:NET_CL_W] net_cpu_run_out)
        else $error("Network CPU wake latency too long.");

endmodule : hfcrc_top

// File: hfcrc_far_model.sv
// Model of the shared power and clock subsystem facing one controller.
// Assumes enables and root requests arrive as levels on the clock.
`timescale 1ns/1ps
module hfcrc_far_model #(
    parameter int DLY = 4
) (
    input  wire logic                    clk_in,
    input  wire logic                    rstn_in,
    input  wire logic                    sys_on_in,
    input  wire logic                    int_en_in,
    input  wire logic                    xo_en_in,
    input  wire hfcrc_pkg::hfcrc_roots_t req_in,
    output logic                         int_rdy_out,
    output logic                         xo_rdy_out,
    output hfcrc_pkg::hfcrc_roots_t      run_out
);
    int ic;
    int xc;
    ////////////////////////////////////////
    // An oscillator needs DLY enabled cycles before it reports ready.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ic <= 0;
            xc <= 0;
        end else begin
            ic <= (int_en_in && sys_on_in) ? ic + 1 : 0;
            xc <= (xo_en_in && sys_on_in) ? xc + 1 : 0;
        end
    end
    assign int_rdy_out = (ic >= DLY);
    assign xo_rdy_out = (xc >= DLY);
    // Roots run only in system-on, while demanded and backed by a source.
    assign run_out = (sys_on_in && (int_rdy_out || xo_rdy_out)) ?
        req_in : '0;
endmodule : hfcrc_far_model

// File: hfcrc_top_bench.sv
// Self-checking bench for the clock request controller.
// Assumes the far-side model stands in for the shared subsystem.
`timescale 1ns/1ps
`include "hfcrc_map.svh"
module hfcrc_top_bench;
    logic mclk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, sys_on_in = 1, er;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out, rd;
    logic [7:0] consumer_req_in = '0, clock_gate_en_out;
    logic [3:0] hw_event_in = '0, wk = '0, periph_event_out;
    logic pready_out, pslverr_out, int_osc_ready_in, xo_ready_in;
    logic int_osc_en_out, xo_en_out, started_event_out;
    logic app_cpu_run_out, net_cpu_run_out;
    hfcrc_pkg::hfcrc_roots_t far_root_req_in = '0, root_running_in;
    hfcrc_pkg::hfcrc_roots_t root_req_out, dem;
    wire [1:0] run = {net_cpu_run_out, app_cpu_run_out};
    int num_errors = 0;
    int num_checks = 0;
    // Row: far demand, local requests, expected roots, expected int osc.
    logic [16:0] rows [7] = '{{4'h0, 8'h01, 4'h1, 1'h1},
        {4'h0, 8'h02, 4'h2, 1'h1}, {4'h0, 8'h04, 4'h4, 1'h1},
        {4'h0, 8'h80, 4'h8, 1'h1}, {4'h0, 8'h58, 4'h6, 1'h1},
        {4'h2, 8'h00, 4'h0, 1'h1}, {4'h0, 8'h00, 4'h0, 1'h0}};
    int wkind [6] = '{0, 1, 2, 3, 0, 2};
    int wt [6] = '{230, 380, 150, 200, 100, 70};
    assign dem = root_req_out | far_root_req_in;
    always #50 mclk_in = ~mclk_in;
    hfcrc_top uut (.mclk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .consumer_req_in, .far_root_req_in, .root_running_in, .sys_on_in,
        .int_osc_ready_in, .xo_ready_in, .hw_event_in,
        .app_wake_idle_in(wk[0]), .app_wake_off_in(wk[1]),
        .net_wake_idle_in(wk[2]), .net_hold_release_in(wk[3]),
        .clock_gate_en_out, .root_req_out, .int_osc_en_out, .xo_en_out,
        .started_event_out, .periph_event_out, .app_cpu_run_out,
        .net_cpu_run_out);
    hfcrc_far_model far (.clk_in(mclk_in), .rstn_in, .sys_on_in,
        .int_en_in(int_osc_en_out), .xo_en_in(xo_en_out), .req_in(dem),
        .int_rdy_out(int_osc_ready_in), .xo_rdy_out(xo_ready_in),
        .run_out(root_running_in));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_in);
        psel_in <= 1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1;
        do begin @(posedge mclk_in); n++; end
        while (pready_out !== 1 && n < 20);
        chk("pready", 1, pready_out);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
    endtask : apb
    task automatic evt(input int lim, output int n);
        n = 0;
        do begin @(posedge mclk_in); n++; end
        while (started_event_out !== 1 && n < lim);
        chk("started", 1, started_event_out);
    endtask : evt
    task automatic end_sim();
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk_in);
        num_errors++;
        end_sim();
    end
    initial begin
        int n;
        int c;
        repeat (6) @(posedge mclk_in);
        chk("gates_reset", 0, clock_gate_en_out);
        rstn_in <= 1;
        repeat (4) @(posedge mclk_in);
        foreach (rows[i]) begin
            {far_root_req_in, consumer_req_in} <= rows[i][16:5];
            n = 0;
            do begin @(posedge mclk_in); n++; end
            while (clock_gate_en_out !== rows[i][12:5] && n < 40);
            repeat (2) @(posedge mclk_in);
            chk("gates", rows[i][12:5], clock_gate_en_out);
            chk("root_req", rows[i][4:1], root_req_out);
            chk("int_osc_en", rows[i][0], int_osc_en_out);
        end
        consumer_req_in <= 8'h01;
        sys_on_in <= 0;
        repeat (8) @(posedge mclk_in);
        chk("gates_off", 0, clock_gate_en_out);
        chk("root_off", 0, root_req_out);
        sys_on_in <= 1;
        hw_event_in <= 4'ha;
        @(posedge mclk_in);
        hw_event_in <= 4'h0;
        @(posedge mclk_in);
        chk("periph_event", 4'ha, periph_event_out);
        apb(1, `HFCRC_OFF_SOURCE_SEL, 32'h0000_0001);
        apb(0, `HFCRC_OFF_STATUS, '0);
        chk("src_before_start", 0, rd[1]);
        apb(1, `HFCRC_OFF_START_TASK, 32'h0000_0001);
        evt(200, n);
        chk("stab_wait", 1, n >= 16);
        apb(0, `HFCRC_OFF_STARTED_EVT, '0);
        chk("evt_flag", 1, rd[0]);
        apb(0, `HFCRC_OFF_STATUS, '0);
        chk("src_after_start", 1, rd[1]);
        chk("xo_en", 1, xo_en_out);
        apb(1, `HFCRC_OFF_START_TASK, 32'h0000_0001);
        evt(10, n);
        chk("fast_start", 1, n <= 2);
        apb(1, `HFCRC_OFF_STOP_TASK, 32'h0000_0001);
        apb(1, `HFCRC_OFF_START_TASK, 32'h0000_0001);
        apb(1, `HFCRC_OFF_START_TASK, 32'h0000_0001);
        c = 0;
        repeat (80) begin @(posedge mclk_in); c += started_event_out; end
        chk("one_event", 1, c);
        apb(0, 12'h0ffc, '0);
        chk("unmapped_err", 1, er);
        chk("unmapped_data", 0, rd);
        for (int i = 0; i < 6; i++) begin
            if (i == 4) apb(1, `HFCRC_OFF_MODE, 32'h0000_0001);
            @(posedge mclk_in);
            wk[wkind[i]] <= 1;
            @(posedge mclk_in);
            wk[wkind[i]] <= 0;
            n = 0;
            do begin @(posedge mclk_in); n++; end
            while ((n < 3 || run[wkind[i] / 2] !== 1) && n < 500);
            chk("wake", 1, n >= wt[i] - 2 && n <= wt[i] + 2);
        end
        end_sim();
    end
endmodule : hfcrc_top_bench
